// ### design/ilbd_pkg.sv
/*
  Package for the inband loopback code detector: register indices, field
  positions, reset values, thresholds and carrier structs.
  Assumes one 50 MHz block clock and an AXI4-Lite master at the registers.
*/
`default_nettype none
package ilbd_pkg;
  // Printed offsets are register indices; the byte address is four times
  localparam logic [11:0] IDX_CONFIG     = 12'h0076;
  localparam logic [11:0] IDX_STATE      = 12'h0077;
  localparam logic [11:0] IDX_ACT_PAT    = 12'h0078;
  localparam logic [11:0] IDX_DEACT_PAT  = 12'h0079;
  localparam logic [11:0] IDX_IRQ_EN     = 12'h007A;
  localparam logic [11:0] IDX_CHG_FLAGS  = 12'h007B;
  localparam int          BYTES_PER_REG  = 4;

  localparam logic [7:0]  RST_CONFIG     = 8'h04;
  localparam logic [7:0]  RST_ACT_PAT    = 8'h08;
  localparam logic [7:0]  RST_DEACT_PAT  = 8'h24;
  localparam logic [7:0]  RST_IRQ_EN     = 8'h00;

  // Config fields
  localparam int CFG_ACT_SEL_LSB   = 0;
  localparam int CFG_DEACT_SEL_LSB = 2;
  localparam int CFG_FBIT_SKIP     = 4;

  // Detector slots; slot index equals the status, enable and flag bit
  localparam int DET_DEACT = 0;
  localparam int DET_ACT   = 1;
  localparam int DET_NUM   = 2;

  localparam int BASE_LEN  = 5;
  localparam int PAT_BITS  = 8;

  localparam int ERR_LIMIT   = 600;
  localparam int GOOD_PERIODS = 126;
  localparam int ERR_W       = 10;
  localparam int GOOD_W      = 7;

  localparam longint PERIOD_NS     = 39_800_000;
  localparam longint CLOCK_NS      = 20;
  localparam int     PERIOD_CYCLES = int'(PERIOD_NS / CLOCK_NS);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic strobe;  // one received bit this cycle
    logic data;    // received bit value
    logic fbit;    // this bit is a framing bit
  } ilbd_rx_s;

  typedef struct packed {
    logic       fbit_skip;
    logic [1:0] deact_len_sel;
    logic [1:0] act_len_sel;
  } ilbd_cfg_s;
endpackage
`default_nettype wire

// ### design/ilbd_detector.sv
/*
  Inband loopback code detector with its AXI4-Lite register file.
  Assumes received bits arrive as one-cycle strobes synchronous to clock,
  and that the AXI master keeps to the AXI4-Lite handshake.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
// Behaviour
// - Deactivate length field picks code length and bits
// - Activate length field uses the same encoding
// - Over 600 activate errors in period clears detect
// - Activate detected after over 126 clean periods
// - Over 600 deactivate errors in period clears detect
// - Deactivate detected after over 126 clean periods
// - Activate code MSB first, unused low bits ignored
// - Deactivate code MSB first, unused low bits ignored
// - Any activate detect transition sets activate flag
// - Any deactivate detect transition sets deactivate flag
// - Flags stay set until one written to them
// - Activate flag drives interrupt only when enabled
// - Deactivate flag drives interrupt only when enabled
// - Framing bits skipped or their result discarded
`default_nettype none
module ilbd_detector
  import ilbd_pkg::*;
#(
  parameter int PERIOD_LEN = PERIOD_CYCLES
) (
  input  wire  logic        clock,
  input  wire  logic        rst,
  input  wire  logic        ce,
  input  wire  ilbd_rx_s    rx,
  input  wire  logic [11:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [11:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  output logic              irq
);
  localparam int PW = $clog2(PERIOD_LEN + 1);

  // True when the newest bits of hist form some rotation of the code.
  // Alignment is free, so no phase search state is needed.
  function automatic logic ilbd_match(input logic [7:0] hist,
                                      input logic [7:0] code,
                                      input logic [1:0] sel);
    int   len;
    int   idx;
    logic ok;
    logic any;
    len = BASE_LEN + int'(sel);
    any = 1'b0;
    for (int r = 0; r < PAT_BITS; r++) begin
      ok = (r < len);
      for (int k = 0; k < PAT_BITS; k++) begin
        if (k < len) begin
          idx = (r + len - 1 - k) % len;
          if (hist[k] != code[PAT_BITS - 1 - idx]) begin
            ok = 1'b0;
          end
        end
      end
      any = any | ok;
    end
    return any;
  endfunction

  // Register storage
  ilbd_cfg_s         cfg_ff;
  logic [7:0]        act_pat_ff;
  logic [7:0]        deact_pat_ff;
  logic [DET_NUM-1:0] irq_en_ff;
  logic [DET_NUM-1:0] flag_ff;
  logic [DET_NUM-1:0] det_ff;

  // AXI holding state
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [11:0]       awaddr_ff;
  logic [7:0]        wdata_ff;
  logic              wstrb0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  // Write path: address and data are caught independently, either order
  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire wr_do    = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [11:0] wr_idx = {2'b00, awaddr_ff[11:2]};
  wire wr_algn  = (awaddr_ff[1:0] == 2'b00);
  wire wr_cfg   = wr_algn && (wr_idx == IDX_CONFIG);
  wire wr_state = wr_algn && (wr_idx == IDX_STATE);
  wire wr_act   = wr_algn && (wr_idx == IDX_ACT_PAT);
  wire wr_deact = wr_algn && (wr_idx == IDX_DEACT_PAT);
  wire wr_en    = wr_algn && (wr_idx == IDX_IRQ_EN);
  wire wr_flag  = wr_algn && (wr_idx == IDX_CHG_FLAGS);
  wire wr_hit   = wr_cfg || wr_state || wr_act || wr_deact
                  || wr_en || wr_flag;
  wire wr_store = wr_do && wstrb0_ff;
  wire [DET_NUM-1:0] flag_clr =
    (wr_store && wr_flag) ? wdata_ff[DET_NUM-1:0] : '0;

  // Handshakes pause with the clock enable, or a transfer seen as taken
  // while frozen would be lost
  assign s_axi_awready = ce && !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = ce && !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = ce && bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 12'h000;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ff       <= ilbd_cfg_s'(RST_CONFIG[4:0]);
      act_pat_ff   <= RST_ACT_PAT;
      deact_pat_ff <= RST_DEACT_PAT;
      irq_en_ff    <= RST_IRQ_EN[DET_NUM-1:0];
    end else if (ce && wr_store) begin
      if (wr_cfg) begin
        cfg_ff <= ilbd_cfg_s'(wdata_ff[4:0]);
      end
      if (wr_act) begin
        act_pat_ff <= wdata_ff;
      end
      if (wr_deact) begin
        deact_pat_ff <= wdata_ff;
      end
      if (wr_en) begin
        irq_en_ff <= wdata_ff[DET_NUM-1:0];
      end
    end
  end

  // Read path: one read in flight, answered the cycle after ar is taken
  wire [11:0] rd_idx  = {2'b00, s_axi_araddr[11:2]};
  wire rd_algn = (s_axi_araddr[1:0] == 2'b00);
  wire [7:0] rd_byte =
    !rd_algn                    ? 8'h00 :
    (rd_idx == IDX_CONFIG)      ? {3'b000, cfg_ff} :
    (rd_idx == IDX_STATE)       ? {6'b00_0000, det_ff} :
    (rd_idx == IDX_ACT_PAT)     ? act_pat_ff :
    (rd_idx == IDX_DEACT_PAT)   ? deact_pat_ff :
    (rd_idx == IDX_IRQ_EN)      ? {6'b00_0000, irq_en_ff} :
    (rd_idx == IDX_CHG_FLAGS)   ? {6'b00_0000, flag_ff} : 8'h00;
  wire rd_hit = rd_algn &&
    (rd_idx >= IDX_CONFIG) && (rd_idx <= IDX_CHG_FLAGS);
  wire ar_fire = s_axi_arvalid && s_axi_arready;

  assign s_axi_arready = ce && !rvalid_ff;
  assign s_axi_rvalid  = ce && rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h00_0000, rd_byte};
        rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Fixed measurement period counted in block clocks
  logic [PW-1:0] period_cnt_ff;
  wire period_end = (period_cnt_ff == PW'(PERIOD_LEN - 1));

  always_ff @(posedge clock) begin
    if (rst) begin
      period_cnt_ff <= '0;
    end else if (ce) begin
      period_cnt_ff <= period_end ? '0 : period_cnt_ff + PW'(1);
    end
  end

  a_period_wrap: assert property (
    @(posedge clock) disable iff (rst)
    (ce && period_end) |=> period_cnt_ff == PW'(0))
    else $error("measurement period did not wrap at its length");

  // In keep mode the framing bit stays in the history so later bits see
  // the true line sequence; only its own verdict is dropped.
  wire bit_shift = rx.strobe && !(rx.fbit && cfg_ff.fbit_skip);
  wire bit_count = rx.strobe && !rx.fbit;

  logic [7:0] hist_ff;
  wire  [7:0] nxt_hist = {hist_ff[6:0], rx.data};

  always_ff @(posedge clock) begin
    if (rst) begin
      hist_ff <= 8'h00;
    end else if (ce && bit_shift) begin
      hist_ff <= nxt_hist;
    end
  end

  wire [7:0] code_sel [DET_NUM];
  wire [1:0] len_sel  [DET_NUM];
  assign code_sel[DET_ACT]   = act_pat_ff;
  assign code_sel[DET_DEACT] = deact_pat_ff;
  assign len_sel[DET_ACT]    = cfg_ff.act_len_sel;
  assign len_sel[DET_DEACT]  = cfg_ff.deact_len_sel;

  logic [ERR_W-1:0]  err_ff  [DET_NUM];
  logic [GOOD_W-1:0] good_ff [DET_NUM];
  logic [DET_NUM-1:0] nxt_det;

  for (genvar i = 0; i < DET_NUM; i++) begin : g_det
    wire hit  = ilbd_match(nxt_hist, code_sel[i], len_sel[i]);
    wire miss = bit_count && !hit;
    wire over = (err_ff[i] > ERR_W'(ERR_LIMIT));
    wire clean = (err_ff[i] < ERR_W'(ERR_LIMIT));
    // Saturate one past the limit so the counter cannot wrap
    wire [ERR_W-1:0] err_inc =
      (miss && !over) ? err_ff[i] + ERR_W'(1) : err_ff[i];
    wire [ERR_W-1:0] nxt_err =
      period_end ? ERR_W'(miss) : err_inc;
    wire [GOOD_W-1:0] nxt_good =
      !period_end ? good_ff[i] :
      !clean      ? '0 :
      (good_ff[i] == '1) ? good_ff[i] : good_ff[i] + GOOD_W'(1);
    wire set_det = period_end && clean &&
      (good_ff[i] >= GOOD_W'(GOOD_PERIODS));

    // Loss wins at once, without waiting for the period to end
    assign nxt_det[i] = over ? 1'b0 :
                        set_det ? 1'b1 : det_ff[i];

    always_ff @(posedge clock) begin
      if (rst) begin
        err_ff[i]  <= '0;
        good_ff[i] <= '0;
        det_ff[i]  <= 1'b0;
        flag_ff[i] <= 1'b0;
      end else if (ce) begin
        err_ff[i]  <= nxt_err;
        good_ff[i] <= nxt_good;
        det_ff[i]  <= nxt_det[i];
        // A transition in the clearing cycle still leaves the flag set
        flag_ff[i] <= (nxt_det[i] != det_ff[i])
                      || (flag_ff[i] && !flag_clr[i]);
      end
    end

    a_chg_sets_flag: assert property (
      @(posedge clock) disable iff (rst)
      (ce && nxt_det[i] != det_ff[i]) |=> flag_ff[i])
      else $error("detect change did not set its flag");

    a_flag_sticky: assert property (
      @(posedge clock) disable iff (rst)
      (ce && flag_ff[i] && !flag_clr[i]) |=> flag_ff[i])
      else $error("change flag dropped without a clearing write");

    a_loss_clears: assert property (
      @(posedge clock) disable iff (rst)
      (ce && err_ff[i] > ERR_W'(ERR_LIMIT)) |=> !det_ff[i])
      else $error("detect held after error limit passed");

    a_detect_needs_run: assert property (
      @(posedge clock) disable iff (rst)
      $rose(det_ff[i]) |->
        $past(period_end) && $past(good_ff[i]) >= GOOD_W'(GOOD_PERIODS)
        && $past(err_ff[i]) < ERR_W'(ERR_LIMIT))
      else $error("detect set without enough clean periods");

    a_period_restart: assert property (
      @(posedge clock) disable iff (rst)
      (ce && period_end) |=> err_ff[i] <= ERR_W'(1))
      else $error("error counter not restarted at period end");

    a_fbit_ignored: assert property (
      @(posedge clock) disable iff (rst)
      (ce && rx.strobe && rx.fbit && !period_end)
        |=> err_ff[i] == $past(err_ff[i]))
      else $error("framing bit counted as a pattern error");

    a_flag_w1c: assert property (
      @(posedge clock) disable iff (rst)
      (ce && flag_clr[i] && nxt_det[i] == det_ff[i]) |=> !flag_ff[i])
      else $error("change flag not cleared by writing one");

    a_good_restart: assert property (
      @(posedge clock) disable iff (rst)
      (ce && period_end && !clean) |=> good_ff[i] == GOOD_W'(0))
      else $error("clean period run not restarted by a bad period");

    a_det_steady: assert property (
      @(posedge clock) disable iff (rst)
      (ce && !period_end && !over) |=> det_ff[i] == $past(det_ff[i]))
      else $error("detect changed away from a period end");

    a_err_saturates: assert property (
      @(posedge clock) disable iff (rst)
      (err_ff[i] <= ERR_W'(ERR_LIMIT + 1)))
      else $error("error counter ran past its saturation point");
  end

  wire [DET_NUM-1:0] irq_src = flag_ff & irq_en_ff;
  assign irq = |irq_src;

  a_irq_act_gate: assert property (
    @(posedge clock) disable iff (rst)
    (flag_ff[DET_ACT] && !irq_en_ff[DET_ACT] && !irq_src[DET_DEACT])
      |-> !irq)
    else $error("masked activate flag drove the interrupt");

  a_irq_follows: assert property (
    @(posedge clock) disable iff (rst)
    (ce && $rose(flag_ff[DET_DEACT]) && irq_en_ff[DET_DEACT])
      |-> irq ##1 (irq || !flag_ff[DET_DEACT] || !irq_en_ff[DET_DEACT]
                   || !ce || $past(!ce)))
    else $error("enabled deactivate flag did not raise interrupt");

  a_irq_deact_gate: assert property (
    @(posedge clock) disable iff (rst)
    (flag_ff[DET_DEACT] && !irq_en_ff[DET_DEACT] && !irq_src[DET_ACT])
      |-> !irq)
    else $error("masked deactivate flag drove the interrupt");

  // A frozen cycle must leave the period counter, history, detects and flags where they were
  a_ce_freeze: assert property (
    @(posedge clock) disable iff (rst)
    !ce |=> $stable(period_cnt_ff) && $stable(det_ff)
            && $stable(flag_ff) && $stable(hist_ff))
    else $error("state moved while the clock enable was low");
endmodule
`default_nettype wire

// ### test/ilbd_line_model.sv
/*
  Far-end line model: repeats a five-bit code one bit a clock, can
  interleave framing bits, or send a stream that breaks every bit.
  Assumes the detector takes a bit at each edge with the strobe high.
*/
`default_nettype none
module ilbd_line_model
  import ilbd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] code,
  input  wire logic [1:0] mode,
  input  wire logic       fbit_on,
  output var  ilbd_rx_s   rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode 0 idle, 1 code, 2 constant zero (no rotation of 10101 fits)
  logic [2:0] pos_ff;
  logic       phase_ff;
  wire  logic is_fbit = fbit_on && phase_ff;
  wire  logic cur_bit = code[3'd7 - pos_ff];

  always_ff @(posedge clock) begin
    if (rst) begin
      pos_ff   <= 3'h0;
      phase_ff <= 1'b0;
      rx       <= '0;
    end else begin
      phase_ff  <= ~phase_ff;
      rx.strobe <= (mode != 2'h0);
      rx.fbit   <= is_fbit;
      if (mode == 2'h0) begin
        // Idle line keeps moving so a stale value is never mistaken
        rx.data <= ~rx.data;
      end else if (is_fbit) begin
        // Wrong on purpose: harmless only while framing bits are skipped
        rx.data <= ~cur_bit;
      end else begin
        rx.data <= (mode == 2'h1) && cur_bit;
      end
      if (mode != 2'h0 && !is_fbit) begin
        pos_ff <= (pos_ff == 3'h4) ? 3'h0 : pos_ff + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
/*
  Self-checking bench for the loopback code detector: AXI4-Lite master
  tasks, one task per scenario, far-end line model on the receive side.
  Assumes a shortened period parameter and a 50 MHz clock.
*/
`default_nettype none
module tb_top
  import ilbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // 620 bits a period, so one corrupt period exceeds the error limit
  localparam int P = 620;
  logic        clock   = 1'b0;
  logic        rst     = 1'b1;
  logic        ce      = 1'b1;
  logic [11:0] awaddr  = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  code    = 8'hA8;
  logic [1:0]  mode    = 2'h1;
  logic        fbit_on = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  ilbd_rx_s    rx;
  int          errors   = 0;
  int          n_checks = 0;
  int          cyc      = 0;
  logic [1:0]  last_bresp = 2'h0;

  ilbd_detector #(.PERIOD_LEN(P)) u_ilbd_detector (
    .clock(clock), .rst(rst), .ce(ce), .rx(rx),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  ilbd_line_model u_ilbd_line_model (
    .clock(clock), .rst(rst), .code(code), .mode(mode),
    .fbit_on(fbit_on), .rx(rx));

  always #10 clock = ~clock;
  always @(posedge clock) cyc <= rst ? 0 : cyc + 1;

  function automatic logic [11:0] ad(input logic [11:0] idx);
    return 12'(idx * BYTES_PER_REG);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready and valid are sampled mid-cycle, where they stand settled
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_ok, w_ok, aw_hit, w_hit, b_hit;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_hit = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clock);
      aw_hit = awready;
      w_hit = wready;
      @(posedge clock);
      if (!aw_ok && aw_hit) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && w_hit) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (!b_hit) begin
      @(negedge clock);
      b_hit = bvalid;
      last_bresp = bresp;
      @(posedge clock);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic hit;
    hit = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit) begin
      @(negedge clock);
      hit = arready;
      @(posedge clock);
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge clock);
      hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
    end
    rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] a,
                      input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, {24'h00_0000, exp}, d);
  endtask

  task automatic ichk(input logic exp);
    logic v;
    @(negedge clock);
    v = irq;
    @(posedge clock);
    chk("irq", {31'h0, exp}, {31'h0, v});
  endtask

  task automatic wait_to(input int c);
    while (cyc < c) @(posedge clock);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rchk("config", ad(IDX_CONFIG), RST_CONFIG);
    rchk("state", ad(IDX_STATE), 8'h00);
    rchk("act code", ad(IDX_ACT_PAT), RST_ACT_PAT);
    rchk("deact code", ad(IDX_DEACT_PAT), RST_DEACT_PAT);
    rchk("irq enable", ad(IDX_IRQ_EN), RST_IRQ_EN);
    rchk("flags", ad(IDX_CHG_FLAGS), 8'h00);
    rd(12'h0F0, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0000_0000, d);
    wr(12'h0F0, 8'h55);
    chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, last_bresp});
    wr(ad(IDX_STATE), 8'hFF);
    chk("state wresp", {30'h0, RESP_OKAY}, {30'h0, last_bresp});
    // Low code bits are garbage: only bits 7 to 3 may count
    wr(ad(IDX_CONFIG), 8'h10);
    wr(ad(IDX_ACT_PAT), 8'hAF);
    wr(ad(IDX_DEACT_PAT), 8'hAB);
    wr(ad(IDX_IRQ_EN), 8'h02);
    rchk("state ro", ad(IDX_STATE), 8'h00);
    rchk("config rw", ad(IDX_CONFIG), 8'h10);
    $display("test reset done");
  endtask

  task automatic t_detect();
    wait_to(126 * P + P / 2);
    rchk("state early", ad(IDX_STATE), 8'h00);
    ichk(1'b0);
    wait_to(127 * P + P / 2);
    rchk("state", ad(IDX_STATE), 8'h03);
    rchk("flags rise", ad(IDX_CHG_FLAGS), 8'h03);
    ichk(1'b1);
    $display("test detect done");
  endtask

  task automatic t_flags();
    wr(ad(IDX_CHG_FLAGS), 8'h01);
    rchk("flags w1c", ad(IDX_CHG_FLAGS), 8'h02);
    wr(ad(IDX_CHG_FLAGS), 8'h00);
    rchk("flags w0", ad(IDX_CHG_FLAGS), 8'h02);
    ichk(1'b1);
    wr(ad(IDX_IRQ_EN), 8'h01);
    ichk(1'b0);
    wr(ad(IDX_CHG_FLAGS), 8'h02);
    rchk("flags clear", ad(IDX_CHG_FLAGS), 8'h00);
    ichk(1'b0);
    $display("test flags done");
  endtask

  task automatic t_loss();
    mode <= 2'h2;
    fbit_on <= 1'b0;
    repeat (P) @(posedge clock);
    // A short freeze inside the bad stretch only delays the loss
    ce <= 1'b0;
    repeat (8) @(posedge clock);
    ce <= 1'b1;
    repeat (P + 12) @(posedge clock);
    rchk("state lost", ad(IDX_STATE), 8'h00);
    rchk("flags fall", ad(IDX_CHG_FLAGS), 8'h03);
    ichk(1'b1);
    wr(ad(IDX_IRQ_EN), 8'h00);
    ichk(1'b0);
    wr(ad(IDX_IRQ_EN), 8'h03);
    ichk(1'b1);
    wr(ad(IDX_CHG_FLAGS), 8'h03);
    ichk(1'b0);
    $display("test loss done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_detect();
    t_flags();
    t_loss();
    conclude();
  end

  // The whole run needs about 80,400 cycles
  initial begin
    #(20 * 90_000);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
